// File: hsf_fault_mgr.sv
// Purpose: Fault supervision, switch enable and alert release logic
// Assumes: Comparator and converter inputs synchronous to mclk
// Notes: Bus protocol engine lives outside and sends event pulses
//
// How it works
// - High input trip: switch off, set bits
// - High clear 100 ms, then retry allowed
// - Low input trip: switch off, set bits
// - Low clear 100 ms, then retry allowed
// - Low input at supply start logs fault
// - Board pin toggle sets board change fault
// - Board removal: switch off, clear seated
// - Insertion clears faults but board change
// - Board low 100 ms copies enable request
// - Sense result over threshold while off: short
// - Feedback low while on: power bad, pull
// - Feedback recovered: release pin, clear present
// - Alert only for enabled latched faults
// - Alert response: reply address, release alert
// - Direct addressing releases pending alert
// - No reassert until new or refreshed fault
// - Host zero writes clear; present faults kept
// - Switch off, reset level, lockout clear faults
// - Without retry, latched high, low and overcurrent faults hold switch off
// - With retry, present bits hold off; high and low also until 100 ms clear
// - Three results refreshed ten times per second
// - Freeze stops updates, results host writable
// - Overcurrent timer expiry: switch off, set bits
// - Host one into high, low or overcurrent fault, retry off, turns switch off
`timescale 1ns/1ns
module hsf_fault_mgr #(
    parameter int QUAL_CYCLES = hsf_pkg::QUAL_CYCLES,
    parameter int REFRESH_CYCLES = hsf_pkg::REFRESH_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire hsf_pkg::hsf_bus_s bus,
    output logic [7:0] rdata,
    input wire logic highInputCmp,
    input wire logic lowInputCmp,
    input wire logic lowResetCmp,
    input wire logic internalSupplyOk,
    input wire logic boardPresentN,
    input wire logic enableRequest,
    input wire logic feedbackLow,
    input wire logic gateDriveLow,
    input wire logic ocTimerExpired,
    input wire logic ocTimerDischarged,
    input wire hsf_pkg::hsf_adc_s adc,
    input wire logic [6:0] devAddr,
    input wire logic araRequest,
    input wire logic araWon,
    input wire logic addressedDirect,
    output logic switchOn,
    output logic alertOut,
    output logic alertOe,
    output logic gpioOut,
    output logic gpioOe,
    output logic adcStart,
    output logic araReplyValid,
    output logic [6:0] araReplyAddr
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] alertEn;
        logic [5:0] status;
        logic [5:0] fault;
        logic [5:0] served;
        logic [2:0][7:0] result;
        logic [hsf_pkg::CNT_W-1:0] highClearCnt;
        logic [hsf_pkg::CNT_W-1:0] lowClearCnt;
        logic [hsf_pkg::CNT_W-1:0] boardLowCnt;
        logic [hsf_pkg::CNT_W-1:0] refreshCnt;
        logic boardPrev;
        logic enablePrev;
        logic switchOn;
        logic alertOe;
        logic gpioOe;
        logic gpioOut;
        logic adcStart;
        logic araReplyValid;
        logic [6:0] araReplyAddr;
        logic [7:0] rdata;
    } hsf_state_s;

    localparam logic [hsf_pkg::CNT_W-1:0] QUAL_END = hsf_pkg::CNT_W'(QUAL_CYCLES);
    localparam logic [hsf_pkg::CNT_W-1:0] REFRESH_END = hsf_pkg::CNT_W'(REFRESH_CYCLES - 1);
    localparam logic [hsf_pkg::CNT_W-1:0] CNT_ONE = hsf_pkg::CNT_W'(1);

    hsf_state_s s;
    hsf_state_s next_s;

    logic boardRise;
    logic boardFall;
    logic enableRise;
    logic enableFall;
    logic boardQualEvent;
    logic pwrBadCond;
    logic fetShortEvent;
    logic fetShortGone;
    logic switchFall;
    logic clearAll;
    logic releaseEvent;
    logic highOk;
    logic lowOk;
    logic ocOk;
    logic [5:0] hwSet;
    logic [5:0] baseFault;
    logic [2:0] resultIdx;

    always_comb begin
        next_s = s;
        next_s.adcStart = 1'b0;
        next_s.araReplyValid = 1'b0;
        next_s.rdata = 8'h00;
        resultIdx = bus.addr - hsf_pkg::REG_RESULT0;

        // Edge detection on pins
        boardRise = boardPresentN & ~s.boardPrev;
        boardFall = ~boardPresentN & s.boardPrev;
        enableRise = enableRequest & ~s.enablePrev;
        enableFall = ~enableRequest & s.enablePrev;
        next_s.boardPrev = boardPresentN;
        next_s.enablePrev = enableRequest;

        // Qualification counters
        if (highInputCmp) begin
            next_s.highClearCnt = '0;
        end else if (s.highClearCnt != QUAL_END) begin
            next_s.highClearCnt = s.highClearCnt + CNT_ONE;
        end
        if (lowInputCmp) begin
            next_s.lowClearCnt = '0;
        end else if (s.lowClearCnt != QUAL_END) begin
            next_s.lowClearCnt = s.lowClearCnt + CNT_ONE;
        end
        if (boardPresentN) begin
            next_s.boardLowCnt = '0;
        end else if (s.boardLowCnt != QUAL_END) begin
            next_s.boardLowCnt = s.boardLowCnt + CNT_ONE;
        end
        boardQualEvent = ~boardPresentN && (s.boardLowCnt == QUAL_END - CNT_ONE);

        // Present bits
        next_s.status[hsf_pkg::F_HIGH] = highInputCmp;
        next_s.status[hsf_pkg::F_LOW] = lowInputCmp;
        if (ocTimerExpired) begin
            next_s.status[hsf_pkg::F_OC] = 1'b1;
        end else if (ocTimerDischarged) begin
            next_s.status[hsf_pkg::F_OC] = 1'b0;
        end
        pwrBadCond = feedbackLow & s.switchOn & ~gateDriveLow;
        if (pwrBadCond) begin
            next_s.status[hsf_pkg::F_PWR_BAD] = 1'b1;
        end else if (~feedbackLow) begin
            next_s.status[hsf_pkg::F_PWR_BAD] = 1'b0;
        end
        if (boardRise) begin
            next_s.status[hsf_pkg::F_BOARD] = 1'b0;
        end else if (boardFall) begin
            next_s.status[hsf_pkg::F_BOARD] = 1'b1;
        end
        fetShortEvent = adc.valid && adc.chan == hsf_pkg::CH_SENSE && ~s.switchOn
            && adc.data >= hsf_pkg::FET_SHORT_CODE;
        fetShortGone = adc.valid && adc.chan == hsf_pkg::CH_SENSE
            && adc.data < hsf_pkg::FET_SHORT_CODE;
        if (fetShortEvent) begin
            next_s.status[hsf_pkg::F_FET] = 1'b1;
        end else if (fetShortGone) begin
            next_s.status[hsf_pkg::F_FET] = 1'b0;
        end

        // Control and alert enable registers
        if (bus.wr && bus.addr == hsf_pkg::REG_CONTROL) begin
            next_s.ctrl = bus.wdata;
        end
        if (bus.wr && bus.addr == hsf_pkg::REG_ALERT_EN) begin
            next_s.alertEn = bus.wdata;
        end
        if (boardQualEvent) begin
            next_s.ctrl[hsf_pkg::CTL_SWITCH_EN] = enableRequest;
        end else if (s.boardLowCnt == QUAL_END && (enableRise || enableFall)) begin
            next_s.ctrl[hsf_pkg::CTL_SWITCH_EN] = enableRequest;
        end
        switchFall = s.ctrl[hsf_pkg::CTL_SWITCH_EN] & ~next_s.ctrl[hsf_pkg::CTL_SWITCH_EN];

        // Latched faults: sets win over every clear except lockout
        hwSet = '0;
        hwSet[hsf_pkg::F_HIGH] = highInputCmp;
        hwSet[hsf_pkg::F_LOW] = lowInputCmp;
        hwSet[hsf_pkg::F_OC] = ocTimerExpired;
        hwSet[hsf_pkg::F_PWR_BAD] = pwrBadCond;
        hwSet[hsf_pkg::F_BOARD] = boardRise | boardFall;
        hwSet[hsf_pkg::F_FET] = fetShortEvent;
        if (~internalSupplyOk) begin
            hwSet = '0;
        end
        baseFault = s.fault;
        if (bus.wr && bus.addr == hsf_pkg::REG_FAULT) begin
            baseFault = bus.wdata[5:0];
        end
        clearAll = switchFall | lowResetCmp | ~internalSupplyOk;
        if (clearAll) begin
            baseFault = '0;
        end else if (boardFall) begin
            baseFault = baseFault & hsf_pkg::KEEP_ON_INSERT;
        end
        next_s.fault = baseFault | hwSet;
        if (internalSupplyOk) begin
            next_s.fault = next_s.fault | (s.fault & s.status & hsf_pkg::KEEP_BY_PRESENT);
        end

        // Alert release bookkeeping
        releaseEvent = s.alertOe & (araWon | addressedDirect);
        next_s.served = s.served & next_s.fault;
        if (releaseEvent) begin
            next_s.served = next_s.served | (s.fault & next_s.fault);
        end
        next_s.alertOe = |(next_s.fault & next_s.alertEn[5:0] & ~next_s.served);
        if (araRequest && s.alertOe) begin
            next_s.araReplyValid = 1'b1;
            next_s.araReplyAddr = devAddr;
        end

        // Switch enable
        highOk = (next_s.highClearCnt == QUAL_END)
            && (next_s.ctrl[hsf_pkg::CTL_HIGH_RETRY] || ~next_s.fault[hsf_pkg::F_HIGH]);
        lowOk = (next_s.lowClearCnt == QUAL_END)
            && (next_s.ctrl[hsf_pkg::CTL_LOW_RETRY] || ~next_s.fault[hsf_pkg::F_LOW]);
        ocOk = ~next_s.status[hsf_pkg::F_OC]
            && (next_s.ctrl[hsf_pkg::CTL_OC_RETRY] || ~next_s.fault[hsf_pkg::F_OC]);
        next_s.switchOn = next_s.ctrl[hsf_pkg::CTL_SWITCH_EN] && next_s.status[hsf_pkg::F_BOARD]
            && ~boardPresentN && highOk && lowOk && ocOk && internalSupplyOk;

        // General pin
        unique case (hsf_pkg::hsf_gpio_e'(next_s.ctrl[hsf_pkg::CTL_GPIO_LO +: 2]))
            hsf_pkg::HSF_GPIO_PWR_GOOD: next_s.gpioOe = next_s.status[hsf_pkg::F_PWR_BAD];
            hsf_pkg::HSF_GPIO_PULL_GOOD: next_s.gpioOe = ~feedbackLow;
            hsf_pkg::HSF_GPIO_OUT: next_s.gpioOe = 1'b1;
            hsf_pkg::HSF_GPIO_IN: next_s.gpioOe = 1'b0;
        endcase

        // Converter results
        if (s.refreshCnt == REFRESH_END) begin
            next_s.refreshCnt = '0;
            next_s.adcStart = 1'b1;
        end else begin
            next_s.refreshCnt = s.refreshCnt + CNT_ONE;
        end
        if (~s.ctrl[hsf_pkg::CTL_FREEZE]) begin
            if (adc.valid && adc.chan <= hsf_pkg::CH_ADIN) begin
                next_s.result[adc.chan] = adc.data;
            end
        end else if (bus.wr && bus.addr >= hsf_pkg::REG_RESULT0
                && bus.addr <= hsf_pkg::REG_RESULT2) begin
            next_s.result[resultIdx[1:0]] = bus.wdata;
        end

        // Read data
        if (bus.rd) begin
            unique case (bus.addr)
                hsf_pkg::REG_CONTROL: next_s.rdata = s.ctrl;
                hsf_pkg::REG_ALERT_EN: next_s.rdata = s.alertEn;
                hsf_pkg::REG_STATUS: next_s.rdata = {2'b00, s.status};
                hsf_pkg::REG_FAULT: next_s.rdata = {2'b00, s.fault};
                3'h4, 3'h5, 3'h6: next_s.rdata = s.result[resultIdx[1:0]];
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.ctrl <= hsf_pkg::CONTROL_RESET;
            s.alertEn <= hsf_pkg::ALERT_EN_RESET;
            s.boardPrev <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign switchOn = s.switchOn;
    assign alertOut = s.gpioOut;
    assign alertOe = s.alertOe;
    assign gpioOut = s.gpioOut;
    assign gpioOe = s.gpioOe;
    assign adcStart = s.adcStart;
    assign araReplyValid = s.araReplyValid;
    assign araReplyAddr = s.araReplyAddr;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence seq_direct_hit;
        addressedDirect && s.alertOe && !bus.wr;
    endsequence

    sequence seq_no_new_fault;
        s.fault == $past(s.fault);
    endsequence

    a_high_trip_off: assert property (highInputCmp |=> !s.switchOn)
        else $error("switch on after high input trip");
    a_high_fault_set: assert property (highInputCmp && internalSupplyOk
        |=> s.status[0] && s.fault[0])
        else $error("high input bits not set");
    a_low_fault_set: assert property (lowInputCmp && internalSupplyOk
        |=> !s.switchOn && s.status[1] && s.fault[1])
        else $error("low input trip not handled");
    a_board_change: assert property ((boardPresentN != s.boardPrev) && internalSupplyOk
        |=> s.fault[4])
        else $error("board change fault missing");
    a_removal_off: assert property (boardPresentN && !s.boardPrev
        |=> !s.switchOn && !s.status[4])
        else $error("removal did not turn switch off");
    a_alert_gate: assert property (s.alertOe |-> |(s.fault & s.alertEn[5:0]))
        else $error("alert without enabled fault");
    a_direct_release: assert property (seq_direct_hit ##1 seq_no_new_fault
        |-> !s.alertOe)
        else $error("alert not released on direct address");
    a_freeze_hold: assert property (s.ctrl[5] && !bus.wr |=> $stable(s.result))
        else $error("results changed while frozen");
    a_fet_short: assert property (adc.valid && adc.chan == 2'h0 && !s.switchOn
        && adc.data >= 8'h07 && internalSupplyOk |=> s.fault[5] && s.status[5])
        else $error("short not flagged");
    a_lockout_clear: assert property (!internalSupplyOk |=> s.fault == 6'h00 && !s.switchOn)
        else $error("faults kept through lockout");
    a_switch_qual: assert property ($rose(s.switchOn)
        |-> s.highClearCnt == QUAL_END && s.lowClearCnt == QUAL_END)
        else $error("switch on before qualification");
    a_oc_latch_off: assert property (s.fault[2] && !s.ctrl[2] |-> !s.switchOn)
        else $error("latched overcurrent did not hold switch off");
    a_oc_expiry: assert property (ocTimerExpired && internalSupplyOk
        |=> !s.switchOn && s.status[2] && s.fault[2])
        else $error("overcurrent expiry not handled");
    a_pwr_bad_pull: assert property (feedbackLow && s.switchOn && !gateDriveLow
        && s.ctrl[7:6] == 2'b00 |=> s.gpioOe && s.status[3])
        else $error("power bad not pulled");
endmodule // hsf_fault_mgr

// File: hsf_host_model.sv
// Purpose: Host side model of the register port
// Assumes: One-cycle strobes, read data one cycle after the strobe
// Notes: The bench calls its tasks hierarchically
`timescale 1ns/1ns
module hsf_host_model (
    input wire logic mclk,
    output hsf_pkg::hsf_bus_s bus,
    input wire logic [7:0] rdata
);
    initial bus = '0;

    // Zeros clear, ones set, results written only while frozen
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '0;
    endtask

    // Read data taken in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '0;
        #1 d = rdata;
    endtask
endmodule // hsf_host_model

// File: hsf_pkg.sv
// Purpose: Constants and types for the fault supervision block
// Assumes: 100 MHz mclk, 8-bit register data
// Notes: Register indices are word offsets on the plain register port
package hsf_pkg;
    // Clock and timing
    localparam int CLK_KHZ = 100000;
    localparam int QUAL_MS = 100;
    localparam int QUAL_CYCLES = QUAL_MS * CLK_KHZ;
    localparam int REFRESH_PER_SEC = 10;
    localparam int REFRESH_CYCLES = (CLK_KHZ * 1000) / REFRESH_PER_SEC;
    localparam int CNT_W = 24;

    // Converter figures
    localparam int FET_SHORT_UV = 2000;
    localparam int SENSE_LSB_UV = 300;
    localparam logic [7:0] FET_SHORT_CODE = 8'((FET_SHORT_UV + SENSE_LSB_UV - 1) / SENSE_LSB_UV);
    localparam logic [1:0] CH_SENSE = 2'h0;
    localparam logic [1:0] CH_SOURCE = 2'h1;
    localparam logic [1:0] CH_ADIN = 2'h2;

    // Register indices
    localparam logic [2:0] REG_CONTROL = 3'h0;
    localparam logic [2:0] REG_ALERT_EN = 3'h1;
    localparam logic [2:0] REG_STATUS = 3'h2;
    localparam logic [2:0] REG_FAULT = 3'h3;
    localparam logic [2:0] REG_RESULT0 = 3'h4;
    localparam logic [2:0] REG_RESULT2 = 3'h6;

    // Control fields
    localparam int CTL_HIGH_RETRY = 0;
    localparam int CTL_LOW_RETRY = 1;
    localparam int CTL_OC_RETRY = 2;
    localparam int CTL_SWITCH_EN = 3;
    localparam int CTL_MASS_WR = 4;
    localparam int CTL_FREEZE = 5;
    localparam int CTL_GPIO_LO = 6;
    localparam logic [7:0] CONTROL_RESET = 8'h13;
    localparam logic [7:0] ALERT_EN_RESET = 8'h00;

    // Status and fault fields
    localparam int F_HIGH = 0;
    localparam int F_LOW = 1;
    localparam int F_OC = 2;
    localparam int F_PWR_BAD = 3;
    localparam int F_BOARD = 4;
    localparam int F_FET = 5;
    localparam logic [5:0] KEEP_BY_PRESENT = 6'h2F;
    localparam logic [5:0] KEEP_ON_INSERT = 6'h10;

    // GPIO modes
    typedef enum logic [1:0] {
        HSF_GPIO_PWR_GOOD = 2'b00,
        HSF_GPIO_PULL_GOOD = 2'b01,
        HSF_GPIO_OUT = 2'b10,
        HSF_GPIO_IN = 2'b11
    } hsf_gpio_e;

    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [7:0] data;
    } hsf_adc_s;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hsf_bus_s;
endpackage

// File: tb_hsf_fault_mgr.sv
// Purpose: Self-checking bench for the fault supervision block
// Assumes: Shortened qualify and refresh counts
// Notes: Registers reached through the host model
`timescale 1ns/1ns
module tb_hsf_fault_mgr;
    localparam int QC = 20;
    localparam int RC = 16;
    localparam logic [2:0] CTL = hsf_pkg::REG_CONTROL;
    localparam logic [2:0] AEN = hsf_pkg::REG_ALERT_EN;
    localparam logic [2:0] STA = hsf_pkg::REG_STATUS;
    localparam logic [2:0] FLT = hsf_pkg::REG_FAULT;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    hsf_pkg::hsf_bus_s bus;
    hsf_pkg::hsf_adc_s adc = '0;
    logic [7:0] rdata;
    logic highInputCmp = 1'b0, lowInputCmp = 1'b1, lowResetCmp = 1'b0;
    logic internalSupplyOk = 1'b0, boardPresentN = 1'b1, enableRequest = 1'b1;
    logic feedbackLow = 1'b0, gateDriveLow = 1'b0;
    logic ocTimerExpired = 1'b0, ocTimerDischarged = 1'b0;
    logic araRequest = 1'b0, araWon = 1'b0, addressedDirect = 1'b0;
    logic [6:0] devAddr = 7'h53;
    logic switchOn, alertOut, alertOe, gpioOut, gpioOe, adcStart, araReplyValid;
    logic [6:0] araReplyAddr;
    int err_count = 0;
    int checks = 0;

    always #5 mclk = ~mclk;

    hsf_host_model host (.mclk(mclk), .bus(bus), .rdata(rdata));
    hsf_fault_mgr #(.QUAL_CYCLES(QC), .REFRESH_CYCLES(RC)) dut (
        .mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata),
        .highInputCmp(highInputCmp), .lowInputCmp(lowInputCmp), .lowResetCmp(lowResetCmp),
        .internalSupplyOk(internalSupplyOk), .boardPresentN(boardPresentN),
        .enableRequest(enableRequest), .feedbackLow(feedbackLow), .gateDriveLow(gateDriveLow),
        .ocTimerExpired(ocTimerExpired), .ocTimerDischarged(ocTimerDischarged), .adc(adc),
        .devAddr(devAddr), .araRequest(araRequest), .araWon(araWon),
        .addressedDirect(addressedDirect), .switchOn(switchOn), .alertOut(alertOut),
        .alertOe(alertOe), .gpioOut(gpioOut), .gpioOe(gpioOe), .adcStart(adcStart),
        .araReplyValid(araReplyValid), .araReplyAddr(araReplyAddr));

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic bchk(input string s, input logic e, input logic g);
        chk(s, {7'h00, e}, {7'h00, g});
    endtask

    task automatic rchk(input string s, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd_reg(a, d);
        chk(s, e, d);
    endtask

    task automatic adc_put(input logic [1:0] c, input logic [7:0] d);
        @(posedge mclk) adc <= '{valid: 1'b1, chan: c, data: d};
        @(posedge mclk) adc.valid <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic t_power_up();
        @(posedge mclk) internalSupplyOk <= 1'b1;
        cyc(3);
        rchk("fault", FLT, 8'h02);
        rchk("control", CTL, hsf_pkg::CONTROL_RESET);
        rchk("alert_en", AEN, 8'h00);
        rchk("unmapped", 3'h7, 8'h00);
        @(posedge mclk) lowInputCmp <= 1'b0;
        @(posedge mclk) boardPresentN <= 1'b0;
        cyc(3);
        rchk("fault", FLT, 8'h10);
        host.wr_reg(STA, 8'h3F);
        rchk("status", STA, 8'h10);
        bchk("switchOn", 1'b0, switchOn);
        cyc(QC + 5);
        bchk("switchOn", 1'b1, switchOn);
        rchk("control", CTL, 8'h1B);
    endtask

    task automatic t_trip_retry();
        logic [7:0] f;
        f = 8'h10;
        for (int i = 0; i < 2; i++) begin
            f[i] = 1'b1;
            @(posedge mclk) {lowInputCmp, highInputCmp} <= 2'b01 << i;
            cyc(2);
            bchk("switchOn", 1'b0, switchOn);
            rchk("status", STA, 8'h10 | (8'h01 << i));
            rchk("fault", FLT, f);
            @(posedge mclk) {lowInputCmp, highInputCmp} <= 2'b00;
            cyc(10);
            @(posedge mclk) {lowInputCmp, highInputCmp} <= 2'b01 << i;
            @(posedge mclk) {lowInputCmp, highInputCmp} <= 2'b00;
            cyc(QC - 5);
            bchk("switchOn", 1'b0, switchOn);
            cyc(10);
            bchk("switchOn", 1'b1, switchOn);
            rchk("fault", FLT, f);
        end
        host.wr_reg(FLT, 8'h00);
        rchk("fault", FLT, 8'h00);
    endtask

    task automatic t_latch_off();
        host.wr_reg(CTL, 8'h18);
        @(posedge mclk) highInputCmp <= 1'b1;
        host.wr_reg(FLT, 8'h00);
        rchk("fault", FLT, 8'h01);
        @(posedge mclk) highInputCmp <= 1'b0;
        cyc(QC + 5);
        bchk("switchOn", 1'b0, switchOn);
        adc_put(hsf_pkg::CH_SENSE, 8'h06);
        rchk("status", STA, 8'h10);
        adc_put(hsf_pkg::CH_SENSE, 8'h07);
        rchk("status", STA, 8'h30);
        rchk("fault", FLT, 8'h21);
        rchk("result0", hsf_pkg::REG_RESULT0, 8'h07);
        adc_put(hsf_pkg::CH_SENSE, 8'h00);
        host.wr_reg(FLT, 8'h00);
        cyc(3);
        bchk("switchOn", 1'b1, switchOn);
        host.wr_reg(FLT, 8'h01);
        cyc(2);
        bchk("switchOn", 1'b0, switchOn);
        host.wr_reg(FLT, 8'h00);
    endtask

    task automatic t_overcurrent();
        @(posedge mclk) ocTimerExpired <= 1'b1;
        @(posedge mclk) ocTimerExpired <= 1'b0;
        cyc(2);
        bchk("switchOn", 1'b0, switchOn);
        rchk("status", STA, 8'h14);
        rchk("fault", FLT, 8'h04);
        @(posedge mclk) ocTimerDischarged <= 1'b1;
        @(posedge mclk) ocTimerDischarged <= 1'b0;
        cyc(QC + 5);
        rchk("status", STA, 8'h10);
        bchk("switchOn", 1'b0, switchOn);
        host.wr_reg(FLT, 8'h00);
        cyc(3);
        bchk("switchOn", 1'b1, switchOn);
    endtask

    task automatic t_power_bad_alert();
        @(posedge mclk) {gateDriveLow, feedbackLow} <= 2'b11;
        cyc(3);
        rchk("status", STA, 8'h10);
        @(posedge mclk) gateDriveLow <= 1'b0;
        cyc(2);
        bchk("gpioOe", 1'b1, gpioOe);
        rchk("status", STA, 8'h18);
        rchk("fault", FLT, 8'h08);
        bchk("alertOe", 1'b0, alertOe);
        host.wr_reg(AEN, 8'h08);
        cyc(1);
        bchk("alertOe", 1'b1, alertOe);
        bchk("alertOut", 1'b0, alertOut);
        bchk("gpioOut", 1'b0, gpioOut);
        @(posedge mclk) araRequest <= 1'b1;
        @(posedge mclk) araRequest <= 1'b0;
        #1 chk("reply", {1'b1, devAddr}, {araReplyValid, araReplyAddr});
        @(posedge mclk) araWon <= 1'b1;
        @(posedge mclk) araWon <= 1'b0;
        cyc(2);
        bchk("alertOe", 1'b0, alertOe);
        @(posedge mclk) feedbackLow <= 1'b0;
        cyc(2);
        bchk("gpioOe", 1'b0, gpioOe);
        rchk("status", STA, 8'h10);
        @(posedge mclk) feedbackLow <= 1'b1;
        cyc(3);
        bchk("alertOe", 1'b0, alertOe);
        @(posedge mclk) feedbackLow <= 1'b0;
        host.wr_reg(FLT, 8'h00);
        @(posedge mclk) feedbackLow <= 1'b1;
        cyc(3);
        bchk("alertOe", 1'b1, alertOe);
        @(posedge mclk) addressedDirect <= 1'b1;
        @(posedge mclk) addressedDirect <= 1'b0;
        cyc(2);
        bchk("alertOe", 1'b0, alertOe);
        @(posedge mclk) feedbackLow <= 1'b0;
        host.wr_reg(AEN, 8'h00);
        host.wr_reg(FLT, 8'h00);
    endtask

    task automatic t_results();
        logic [7:0] n;
        n = 8'h00;
        host.wr_reg(CTL, 8'h38);
        adc_put(hsf_pkg::CH_SOURCE, 8'h33);
        rchk("result1", 3'h5, 8'h00);
        host.wr_reg(3'h5, 8'h5A);
        rchk("result1", 3'h5, 8'h5A);
        host.wr_reg(CTL, 8'h18);
        adc_put(hsf_pkg::CH_ADIN, 8'h44);
        rchk("result2", hsf_pkg::REG_RESULT2, 8'h44);
        for (int m = 1; m < 4; m++) begin
            host.wr_reg(CTL, {2'(m), 6'h18});
            cyc(1);
            bchk("gpioOe", m != 3, gpioOe);
        end
        host.wr_reg(CTL, 8'h18);
        repeat (4 * RC) begin
            cyc(1);
            if (adcStart === 1'b1) n++;
        end
        chk("adcStart", 8'h04, n);
    endtask

    task automatic t_clearing();
        host.wr_reg(FLT, 8'h10);
        @(posedge mclk) enableRequest <= 1'b0;
        cyc(3);
        bchk("switchOn", 1'b0, switchOn);
        rchk("fault", FLT, 8'h00);
        @(posedge mclk) enableRequest <= 1'b1;
        host.wr_reg(FLT, 8'h10);
        @(posedge mclk) lowResetCmp <= 1'b1;
        @(posedge mclk) lowResetCmp <= 1'b0;
        cyc(2);
        rchk("fault", FLT, 8'h00);
        @(posedge mclk) boardPresentN <= 1'b1;
        cyc(2);
        bchk("switchOn", 1'b0, switchOn);
        rchk("status", STA, 8'h00);
        rchk("fault", FLT, 8'h10);
        host.wr_reg(FLT, 8'h30);
        @(posedge mclk) boardPresentN <= 1'b0;
        cyc(3);
        rchk("fault", FLT, 8'h10);
        cyc(QC + 5);
        bchk("switchOn", 1'b1, switchOn);
        @(posedge mclk) internalSupplyOk <= 1'b0;
        cyc(3);
        bchk("switchOn", 1'b0, switchOn);
        rchk("fault", FLT, 8'h00);
    endtask

    initial begin
        cyc(16);
        @(posedge mclk) resetn <= 1'b1;
        t_power_up();
        t_trip_retry();
        t_latch_off();
        t_overcurrent();
        t_power_bad_alert();
        t_results();
        t_clearing();
        conclude();
    end

    initial begin
        #300000;
        err_count++;
        conclude();
    end
endmodule // tb_hsf_fault_mgr
